// file: rtl/sleep_clk_regs.svh
`ifndef SLEEP_CLK_REGS_SVH
`define SLEEP_CLK_REGS_SVH
`define SCG_OFS_PCS        8'h35
`define SCG_OFS_SMC        8'h3A
`define SCG_OFS_DIDR       8'h3B
`define SCG_OFS_STAT       8'h3C
`define SCG_PCS_RESET      8'h00
`define SCG_SMC_RESET      8'h00
`define SCG_BIT_USART      2
`define SCG_BIT_ADC        1
`define SCG_BIT_TIMER      0
`define SCG_BIT_ARM        0
`define SCG_SEL_HI         3
`define SCG_SEL_LO         1
`define SCG_WAKE_HALT      4
`endif

// file: rtl/scg_pkg.sv
package scg_pkg;
  typedef enum logic [2:0] {
    SCG_IDLE  = 3'h0,
    SCG_NOISE = 3'h1,
    SCG_DOWN  = 3'h2,
    SCG_STBY  = 3'h4
  } scg_mode_t;
  typedef enum logic [1:0] {
    SCG_RUN   = 2'h0,
    SCG_SLEEP = 2'h1,
    SCG_START = 2'h3,
    SCG_HALT  = 2'h2
  } scg_state_t;
endpackage : scg_pkg

// file: rtl/scg_ctrl.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "sleep_clk_regs.svh"
module scg_ctrl #(
  parameter int PINS    = 8,
  parameter int START_W = 8
) (
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RESETN,
  input  wire logic                 I_CLK_EN,
  input  wire logic [7:0]           I_AVS_ADDRESS,
  input  wire logic                 I_AVS_READ,
  input  wire logic                 I_AVS_WRITE,
  input  wire logic [31:0]          I_AVS_WRITEDATA,
  input  wire logic [3:0]           I_AVS_BYTEENABLE,
  output logic      [31:0]          O_AVS_READDATA,
  output logic                      O_AVS_WAITREQUEST,
  input  wire logic                 I_SLEEP_INSTR,
  input  wire logic                 I_WAKE_IRQ,
  input  wire logic                 I_WAKE_ASYNC,
  input  wire logic                 I_WDT_RESET,
  input  wire logic [START_W-1:0]   I_START_CYCLES,
  input  wire logic                 I_AC_ENABLE,
  input  wire logic                 I_AC_USES_REF,
  input  wire logic                 I_ADC_ENABLE,
  input  wire logic                 I_AC_MUX_REQ,
  input  wire logic [PINS-1:0]      I_WAKE_PIN_MASK,
  output logic                      O_CORE_CLK_EN,
  output logic                      O_NVM_CLK_EN,
  output logic                      O_IO_CLK_EN,
  output logic                      O_ADC_CLK_EN,
  output logic                      O_USART_CLK_EN,
  output logic                      O_TIMER_CLK_EN,
  output logic                      O_ADC_DOM_CLK_EN,
  output logic                      O_OSC_EN,
  output logic                      O_WDT_CLK_EN,
  output logic                      O_AC_FORCE_OFF,
  output logic                      O_AC_MUX_GRANT,
  output logic                      O_VREF_EN,
  output logic                      O_ADC_EXTENDED,
  output logic [PINS-1:0]           O_INBUF_EN,
  output logic                      O_SLEEPING
);
  import scg_pkg::*;

  // Block summary for the next reader:
  // - Two software registers: peripheral stop bits and sleep control.
  // - An input disable register and a read-only status word sit beside them.
  // - The core raises a one-cycle sleep strobe; the arm bit and a legal
  //   select code decide whether anything happens at all.
  // - Sleep, start-up and halt are walked by a small sequencer.
  // - Every output is registered, so each enable lags its cause by one edge.
  //
  // Bus timing:
  // - A request seen at one edge drops waitrequest for the following cycle.
  // - Writes land at the edge where the master samples waitrequest low,
  //   never earlier, so a request that is withdrawn changes nothing.
  // - Read data is captured together with the waitrequest drop and stands
  //   for exactly that one cycle.
  // - Each access costs two cycles; back to back accesses are fine.
  //
  // Wake timing:
  // - Power-down restarts the oscillator and waits the start-up count.
  // - Standby keeps the oscillator, so it skips that wait.
  // - The shallow modes skip it too, their clocks never stopped.
  // - The core then stays halted four more cycles before it runs.
  //
  // Clock domains per mode:
  // - Idle: core and memory stopped, I/O and converter clocks run.
  // - Noise: I/O stopped as well, converter clock keeps running.
  // - Power-down and standby: every generated clock but the watchdog's stopped.
  // - Watchdog clock is never gated, whatever the mode.
  //
  // Limitations:
  // - Peripheral register blocking comes from the peripheral's gated clock.
  // - A wake source must stand until the sequencer has left sleep.
  // - Reserved select codes make the sleep strobe a no-op.

  logic [7:0]      pcs_r;
  logic [7:0]      smc_r;
  logic [PINS-1:0] didr_r;
  scg_state_t      st_r;
  scg_mode_t       mode_r;
  logic [START_W-1:0] cnt_r;
  logic            ack_r;
  logic            adc_en_d_r;
  logic            wa_s1_r;
  logic            wa_s2_r;
  logic            wa_s3_r;
  logic            wa_r;

  // Legal select code check, reserved codes map to no mode
  function automatic logic scg_legal(input logic [2:0] s);
    scg_legal = (s == SCG_IDLE) || (s == SCG_NOISE) || (s == SCG_DOWN) || (s == SCG_STBY);
  endfunction : scg_legal

  // I/O-side clocks may run only while awake or in idle; shared by several
  // enables so that they can never disagree about the mode
  function automatic logic scg_io_run(input logic slp, input scg_mode_t md);
    scg_io_run = !slp || (md == SCG_IDLE);
  endfunction : scg_io_run

  // Low lane merge; upper lanes carry nothing for these 8-bit registers
  function automatic logic [7:0] scg_merge(input logic [7:0] old, input logic [31:0] d,
                                           input logic be);
    scg_merge = be ? d[7:0] : old;
  endfunction : scg_merge

  // Write commits in the answer cycle, the edge where waitrequest is seen low
  wire logic       wr_hit = I_AVS_WRITE && ack_r == 1'b1;
  wire logic [2:0] sel    = smc_r[`SCG_SEL_HI:`SCG_SEL_LO];
  wire logic       asleep = (st_r != SCG_RUN);
  wire logic       deep   = asleep && (mode_r == SCG_DOWN || mode_r == SCG_STBY);

  // One wait cycle per access keeps the slave simple and the answer fixed.
  // ack_r marks the answer cycle; it drops again at the next edge, so a
  // master that keeps its request up is answered every second cycle.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      ack_r <= 1'b0;
    end else if (I_CLK_EN) begin
      ack_r <= (I_AVS_READ || I_AVS_WRITE) && !ack_r;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else if (I_CLK_EN) begin
      O_AVS_WAITREQUEST <= !((I_AVS_READ || I_AVS_WRITE) && !ack_r);
    end
  end

  // Register writes; stop bits only ever gate the clock, state is kept
  // Unused register bits are masked so that they always read back as zero.
  // Only lane zero matters; writes with it cleared are acked and dropped.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      pcs_r  <= `SCG_PCS_RESET;
      smc_r  <= `SCG_SMC_RESET;
      didr_r <= '0;
    end else if (I_CLK_EN && wr_hit && I_AVS_BYTEENABLE[0]) begin
      case (I_AVS_ADDRESS)
        `SCG_OFS_PCS:  pcs_r  <= scg_merge(pcs_r, I_AVS_WRITEDATA, 1'b1) & 8'h07;
        `SCG_OFS_SMC:  smc_r  <= scg_merge(smc_r, I_AVS_WRITEDATA, 1'b1) & 8'h0F;
        `SCG_OFS_DIDR: didr_r <= I_AVS_WRITEDATA[PINS-1:0];
        default:       smc_r  <= smc_r;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  // Captured every enabled cycle, so the value in the answer cycle is the one
  // addressed when the request was first seen.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_AVS_READDATA <= 32'h0;
    end else if (I_CLK_EN) begin
      case (I_AVS_ADDRESS)
        `SCG_OFS_PCS:  O_AVS_READDATA <= {24'h0, pcs_r};
        `SCG_OFS_SMC:  O_AVS_READDATA <= {24'h0, smc_r};
        `SCG_OFS_DIDR: O_AVS_READDATA <= 32'(didr_r);
        `SCG_OFS_STAT: O_AVS_READDATA <= {27'h0, mode_r, st_r};
        default:       O_AVS_READDATA <= 32'h0;
      endcase
    end
  end

  // Async wake source: three flops, act when stages two and three agree
  // Only the second stage reads the first, which limits metastability to
  // one flop; the agreement test also swallows single-cycle glitches.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      wa_s1_r <= 1'b0;
      wa_s2_r <= 1'b0;
      wa_s3_r <= 1'b0;
      wa_r    <= 1'b0;
    end else if (I_CLK_EN) begin
      wa_s1_r <= I_WAKE_ASYNC;
      wa_s2_r <= wa_s1_r;
      wa_s3_r <= wa_s2_r;
      if (wa_s2_r == wa_s3_r) begin
        wa_r <= wa_s3_r;
      end
    end
  end

  // Sleep sequencer; deep modes wake only from watchdog or async pin sources
  // RUN -> SLEEP -> START -> HALT -> RUN, one Gray step at a time.
  // START counts the oscillator start-up, HALT the extra four core cycles.
  // The mode is latched on entry so a later register write cannot change
  // which clocks stay stopped while asleep.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      st_r   <= SCG_RUN;
      mode_r <= SCG_IDLE;
      cnt_r  <= '0;
    end else if (I_CLK_EN) begin
      case (st_r)
        SCG_RUN: begin
          if (I_SLEEP_INSTR && smc_r[`SCG_BIT_ARM] && scg_legal(sel)) begin
            st_r   <= SCG_SLEEP;
            mode_r <= scg_mode_t'(sel);
          end
        end
        // Interrupts wake the shallow modes, synced pins and watchdog any mode
        SCG_SLEEP: begin
          if (I_WDT_RESET || wa_r || (!deep && I_WAKE_IRQ)) begin
            st_r  <= SCG_START;
            // Standby keeps the oscillator, so no start-up wait
            cnt_r <= (mode_r == SCG_DOWN) ? I_START_CYCLES : '0;
          end
        end
        // Oscillator start-up; zero for every mode but power-down
        SCG_START: begin
          if (cnt_r == '0) begin
            st_r  <= SCG_HALT;
            cnt_r <= START_W'(`SCG_WAKE_HALT - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        // Core held for the fixed extra cycles before it may run
        SCG_HALT: begin
          if (cnt_r == '0) begin
            st_r <= SCG_RUN;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: st_r <= SCG_RUN;
      endcase
    end
  end

  // Domain clock enables per mode
  // Every enable but O_OSC_EN keeps its sleep value through START and HALT as well: the core must not run
  // before the halt span ends, and the other domains follow the mode.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_CORE_CLK_EN    <= 1'b1;
      O_NVM_CLK_EN     <= 1'b1;
      O_IO_CLK_EN      <= 1'b1;
      O_ADC_DOM_CLK_EN <= 1'b1;
      O_OSC_EN         <= 1'b1;
      O_WDT_CLK_EN     <= 1'b1;
      O_SLEEPING       <= 1'b0;
    end else if (I_CLK_EN) begin
      O_CORE_CLK_EN    <= !asleep;
      O_NVM_CLK_EN     <= !asleep;
      O_IO_CLK_EN      <= scg_io_run(asleep, mode_r);
      O_ADC_DOM_CLK_EN <= !asleep || !deep;
      O_OSC_EN         <= !(st_r == SCG_SLEEP && mode_r == SCG_DOWN);
      O_WDT_CLK_EN     <= 1'b1;
      O_SLEEPING       <= asleep;
    end
  end

  // Peripheral clocks: stop bit gates in active/idle, and for the ADC in noise too; deeper modes stop anyway
  // Gating the clock freezes the peripheral, so registers ignore access
  // Clearing a stop bit simply lets the clock run again; nothing is reset,
  // which is what lets a restarted timer carry on from its old count.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_USART_CLK_EN <= 1'b1;
      O_TIMER_CLK_EN <= 1'b1;
      O_ADC_CLK_EN   <= 1'b1;
    end else if (I_CLK_EN) begin
      O_USART_CLK_EN <= !pcs_r[`SCG_BIT_USART] && scg_io_run(asleep, mode_r);
      O_TIMER_CLK_EN <= !pcs_r[`SCG_BIT_TIMER] && scg_io_run(asleep, mode_r);
      O_ADC_CLK_EN   <= !pcs_r[`SCG_BIT_ADC] && (!asleep || !deep);
    end
  end

  // Analog housekeeping
  // The mux grant follows the converter clock, so a converter stopped by a
  // deep mode cannot lend its mux either.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_AC_FORCE_OFF <= 1'b0;
      O_AC_MUX_GRANT <= 1'b0;
      O_VREF_EN      <= 1'b0;
      adc_en_d_r     <= 1'b0;
      O_ADC_EXTENDED <= 1'b0;
    end else if (I_CLK_EN) begin
      O_AC_FORCE_OFF <= asleep && mode_r == SCG_DOWN;
      O_AC_MUX_GRANT <= I_AC_MUX_REQ && !pcs_r[`SCG_BIT_ADC] && (!asleep || !deep);
      O_VREF_EN      <= (I_AC_ENABLE && I_AC_USES_REF) || I_ADC_ENABLE;
      adc_en_d_r     <= I_ADC_ENABLE;
      // Flag the next conversion as extended after any off-to-on edge
      if (I_ADC_ENABLE && !adc_en_d_r) begin
        O_ADC_EXTENDED <= 1'b1;
      end else if (!I_ADC_ENABLE) begin
        O_ADC_EXTENDED <= 1'b0;
      end
    end
  end

  // Input buffers: user disable always wins; I/O-clock-stopped modes keep wake pins only
  // Floating inputs burn current in their buffers, hence the cut in sleep.
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_INBUF_EN <= '1;
    end else if (I_CLK_EN) begin
      if (!scg_io_run(asleep, mode_r)) begin
        O_INBUF_EN <= I_WAKE_PIN_MASK & ~didr_r;
      end else begin
        O_INBUF_EN <= ~didr_r;
      end
    end
  end
endmodule : scg_ctrl

// file: dv/scg_timer_model.sv
`timescale 1ns/1ps
// Gated timer on the far side: counts only while its clock enable is high
module scg_timer_model (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_clk_en,
  output logic      [7:0] o_count
);
  // State holds while gated, so a restart resumes the same count
  always_ff @(posedge i_clock) begin
    if (!i_resetn) o_count <= 8'h00;
    else if (i_clk_en) o_count <= o_count + 8'h01;
  end
endmodule : scg_timer_model

// file: dv/scg_ctrl_chk.sv
`timescale 1ns/1ps
module scg_ctrl_chk #(
  parameter int PINS = 8
) (
  input wire logic            I_CLOCK,
  input wire logic            I_RESETN,
  input wire logic            I_AVS_READ,
  input wire logic            I_AVS_WRITE,
  input wire logic            I_AC_ENABLE,
  input wire logic            I_AC_USES_REF,
  input wire logic            I_ADC_ENABLE,
  input wire logic            I_SLEEP_INSTR,
  input wire logic [PINS-1:0] I_WAKE_PIN_MASK,
  input wire logic            O_AVS_WAITREQUEST,
  input wire logic            O_CORE_CLK_EN,
  input wire logic            O_NVM_CLK_EN,
  input wire logic            O_IO_CLK_EN,
  input wire logic            O_USART_CLK_EN,
  input wire logic            O_TIMER_CLK_EN,
  input wire logic            O_ADC_CLK_EN,
  input wire logic            O_AC_MUX_GRANT,
  input wire logic            O_VREF_EN,
  input wire logic            O_WDT_CLK_EN,
  input wire logic [PINS-1:0] O_INBUF_EN,
  input wire logic            O_SLEEPING
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  // Deep modes are judged only once settled, since enables are registered
  a_wdt_on: assert property (O_WDT_CLK_EN) else $error("watchdog gated");
  a_core_asleep: assert property (O_SLEEPING |-> !O_CORE_CLK_EN && !O_NVM_CLK_EN)
    else $error("core clock runs in sleep");
  a_deep_periph: assert property ((O_SLEEPING && !O_IO_CLK_EN) [*2] |->
    !O_USART_CLK_EN && !O_TIMER_CLK_EN) else $error("peripheral clock in deep sleep");
  a_inbuf_off: assert property ((O_SLEEPING && !O_IO_CLK_EN) [*2] |->
    (O_INBUF_EN & ~I_WAKE_PIN_MASK) == '0) else $error("input buffer left on");
  a_sleep_entry: assert property ($rose(O_SLEEPING) |-> $past(I_SLEEP_INSTR, 2))
    else $error("sleep without instruction");
  a_vref_need: assert property ((I_ADC_ENABLE || I_AC_ENABLE && I_AC_USES_REF) [*3] |->
    O_VREF_EN) else $error("reference off while needed");
  a_vref_idle: assert property (!(I_ADC_ENABLE || I_AC_ENABLE && I_AC_USES_REF) [*3] |->
    !O_VREF_EN) else $error("reference on while unneeded");
  a_mux_block: assert property ((!O_ADC_CLK_EN) [*2] |-> !O_AC_MUX_GRANT)
    else $error("mux granted while converter stopped");
  a_bus_answer: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |->
    ##[0:2] !O_AVS_WAITREQUEST) else $error("bus not answered");
  a_wait_once: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
endmodule : scg_ctrl_chk
bind scg_ctrl scg_ctrl_chk #(.PINS(PINS)) u_scg_ctrl_chk (.*);

// file: dv/sleep_and_clock_gating_ctrl_tb_top.sv
`timescale 1ns/1ps
module sleep_and_clock_gating_ctrl_tb_top;
  logic I_CLOCK = 0, I_RESETN = 0, I_AVS_READ = 0, I_AVS_WRITE = 0, I_SLEEP_INSTR = 0;
  logic I_WAKE_IRQ = 0, I_WAKE_ASYNC = 0, I_AC_ENABLE = 0, I_AC_USES_REF = 0;
  logic I_ADC_ENABLE = 0, I_AC_MUX_REQ = 0;
  logic [7:0] I_AVS_ADDRESS = 8'h00, I_WAKE_PIN_MASK = 8'h00, tcnt, c, d;
  logic [31:0] I_AVS_WRITEDATA = 32'h0, O_AVS_READDATA, q;
  logic O_AVS_WAITREQUEST, O_CORE_CLK_EN, O_NVM_CLK_EN, O_IO_CLK_EN, O_ADC_CLK_EN;
  logic O_USART_CLK_EN, O_TIMER_CLK_EN, O_ADC_DOM_CLK_EN, O_OSC_EN, O_WDT_CLK_EN;
  logic O_AC_FORCE_OFF, O_AC_MUX_GRANT, O_VREF_EN, O_ADC_EXTENDED, O_SLEEPING;
  logic [7:0] O_INBUF_EN;
  int num_errors = 0, checked = 0, cyc = 0, m, n, st, seed = 32'h31EA1434;
  int modes[5] = '{0, 1, 2, 4, 3};
  // Run enable, lanes, watchdog wake and start-up count held fixed
  scg_ctrl u_scg_ctrl (.*, .I_CLK_EN(1'b1), .I_AVS_BYTEENABLE(4'hF), .I_WDT_RESET(1'b0),
    .I_START_CYCLES(8'h03));
  scg_timer_model u_scg_timer_model (.i_clock(I_CLOCK), .i_resetn(I_RESETN),
    .i_clk_en(O_TIMER_CLK_EN), .o_count(tcnt));
  initial forever #25 I_CLOCK = ~I_CLOCK;
  task automatic final_report();
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge I_CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge I_CLOCK);
    {I_AVS_READ, I_AVS_WRITE, I_AVS_ADDRESS, I_AVS_WRITEDATA} <= {!wr, wr, a, 24'h0, v};
    do @(posedge I_CLOCK); while (O_AVS_WAITREQUEST !== 1'b0);
    q = O_AVS_READDATA;
    {I_AVS_READ, I_AVS_WRITE} <= 2'b00;
  endtask : bus
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLOCK);
    #1;
  endtask : tick
  task automatic sleep_cmd(input logic [7:0] v);
    bus(1'b1, 8'h3A, v);
    @(posedge I_CLOCK) I_SLEEP_INSTR <= 1'b1;
    @(posedge I_CLOCK) I_SLEEP_INSTR <= 1'b0;
    tick(4);
  endtask : sleep_cmd
  initial begin
    I_WAKE_PIN_MASK = $random(seed);
    tick(16);
    @(posedge I_CLOCK) I_RESETN <= 1'b1;
    bus(1'b0, 8'h35, 8'h00); chk("stop reset", 32'h0, q);
    bus(1'b0, 8'h3A, 8'h00); chk("ctrl reset", 32'h0, q);
    bus(1'b1, 8'h50, 8'hA5); bus(1'b0, 8'h50, 8'h00); chk("unmapped", 32'h0, q);
    // Peripheral stop: read back, enables and frozen or running timer
    repeat (6) begin
      d = $random(seed) & 8'h07;
      bus(1'b1, 8'h35, d); bus(1'b0, 8'h35, 8'h00); chk("stop reg", {24'h0, d}, q);
      tick(3);
      chk("usart en", !d[2], O_USART_CLK_EN); chk("adc en", !d[1], O_ADC_CLK_EN);
      c = tcnt; tick(4);
      chk("timer", d[0] ? c : c + 8'h04, tcnt);
    end
    bus(1'b1, 8'h35, 8'h00); // Restart leaves USART re-init to software
    // Reference enable against comparator and converter needs
    repeat (8) begin
      @(posedge I_CLOCK);
      {I_AC_ENABLE, I_AC_USES_REF, I_ADC_ENABLE, I_AC_MUX_REQ} <= $random(seed);
      tick(4);
      chk("vref", I_ADC_ENABLE | I_AC_ENABLE & I_AC_USES_REF, O_VREF_EN);
      chk("mux grant", I_AC_MUX_REQ, O_AC_MUX_GRANT);
    end
    @(posedge I_CLOCK) I_ADC_ENABLE <= 1'b0;
    tick(3);
    chk("adc ext off", 32'h0, O_ADC_EXTENDED);
    @(posedge I_CLOCK) I_ADC_ENABLE <= 1'b1;
    tick(3);
    chk("adc ext", 32'h1, O_ADC_EXTENDED);
    d = $random(seed); bus(1'b1, 8'h3B, d); tick(3);
    chk("inbuf", {24'h0, ~d}, O_INBUF_EN);
    bus(1'b1, 8'h3B, 8'h00);
    sleep_cmd(8'h00); chk("unarmed", 1'b0, O_SLEEPING);
    // Every legal select code and reserved code 3, then wake and count the halt
    foreach (modes[i]) begin
      m = modes[i];
      sleep_cmd({4'h0, m[2:0], 1'b1});
      chk("sleeping", m != 3, O_SLEEPING);
      chk("core en", m == 3, O_CORE_CLK_EN);
      chk("nvm en", m == 3, O_NVM_CLK_EN);
      chk("ac off", m == 2, O_AC_FORCE_OFF);
      chk("io en", m == 0 || m == 3, O_IO_CLK_EN);
      chk("adc dom", m < 2 || m == 3, O_ADC_DOM_CLK_EN);
      chk("osc", m != 2, O_OSC_EN);
      if (m != 3) begin
        st = (m == 2) ? 4 : 1;
        @(posedge I_CLOCK) if (m < 2) I_WAKE_IRQ <= 1'b1; else I_WAKE_ASYNC <= 1'b1;
        n = 0;
        do begin @(posedge I_CLOCK); n++; end while (O_CORE_CLK_EN !== 1'b1);
        {I_WAKE_IRQ, I_WAKE_ASYNC} <= 2'b00;
        chk("halt span", 1'b1, n >= st + 4);
      end
      bus(1'b1, 8'h3A, 8'h00);
    end
    final_report();
  end
endmodule : sleep_and_clock_gating_ctrl_tb_top
